// ### foc_gain_pkg.sv
package foc_gain_pkg;

    // ------------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_GAIN_A      = 8'h8C;
    localparam logic [7:0]  IDX_SPEED       = 8'h8E;
    localparam logic [7:0]  IDX_REF_A       = 8'h94;
    localparam logic [9:0]  ADDR_GAIN_A     = {IDX_GAIN_A, 2'b00};
    localparam logic [9:0]  ADDR_SPEED      = {IDX_SPEED, 2'b00};
    localparam logic [9:0]  ADDR_REF_A      = {IDX_REF_A, 2'b00};

    // ------------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_GAIN_A      = 32'h0000_0000;
    localparam logic [31:0] RST_SPEED       = 32'h0000_0000;
    localparam logic [31:0] RST_REF_A       = 32'h0000_0000;
    localparam logic [31:0] REG_MASK        = 32'h7FFF_FFFF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned EMF_LSB         = 23;
    localparam int unsigned EMF_W           = 8;
    localparam int unsigned GAIN_W          = 10;
    localparam int unsigned GAIN_VAL_W      = 8;
    localparam int unsigned CKP_LSB         = 13;
    localparam int unsigned CKI_LSB         = 3;
    localparam int unsigned SKP_HI_W        = 3;
    localparam int unsigned SKP_LO_LSB      = 24;
    localparam int unsigned SKP_LO_W        = 7;
    localparam int unsigned SKI_LSB         = 14;
    localparam int unsigned SPD_LSB         = 0;
    localparam int unsigned SPD_W           = 14;
    localparam int unsigned SHAPE_LSB       = 29;
    localparam int unsigned DUTY_LSB        = 21;
    localparam int unsigned DUTY_W          = 8;

    // ------------------------------------------------------------------
    // decode constants
    // ------------------------------------------------------------------
    localparam int unsigned NUMER_W         = 18;
    localparam int unsigned EXP_W           = 3;
    localparam int unsigned HZ_W            = 12;
    localparam int unsigned PCT_W           = 7;
    localparam int unsigned CKP_MULT        = 1;
    localparam int unsigned CKI_MULT        = 1000;
    localparam int unsigned SKP_EXTRA_EXP   = 2;
    localparam int unsigned SKI_EXTRA_EXP   = 1;
    localparam int unsigned SPD_DIV         = 6;
    localparam int unsigned DUTY_FULL       = 255;
    localparam int unsigned PCT_FULL        = 100;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [3:0] {
        SHAPE_EQUATION  = 4'b0001,
        SHAPE_LINEAR    = 4'b0010,
        SHAPE_STAIRCASE = 4'b0100,
        SHAPE_FWD_REV   = 4'b1000
    } shape_t;

endpackage: foc_gain_pkg

// ### gain_if.sv
`timescale 1ns/100ps
interface gain_if;
    import foc_gain_pkg::*;
    logic [GAIN_W-1:0]  code;
    logic [NUMER_W-1:0] numer;
    logic [EXP_W-1:0]   expo;
    modport src (output code, input numer, input expo);
    modport dec (input code, output numer, output expo);
endinterface: gain_if

// ### gain_decode.sv
`timescale 1ns/100ps
// splits a scale/value gain code into numerator and power-of-ten divisor
module gain_decode #(
    parameter int unsigned MULT      = 1,
    parameter int unsigned EXTRA_EXP = 0
) (
    // gain code in, decoded gain out
    gain_if.dec g
);
    import foc_gain_pkg::*;

    always_comb
    begin
        g.numer = NUMER_W'(g.code[GAIN_VAL_W-1:0]) * NUMER_W'(MULT);
        g.expo  = EXP_W'(g.code[GAIN_W-1:GAIN_VAL_W]) + EXP_W'(EXTRA_EXP);
    end

endmodule: gain_decode

// ### ratio_scale.sv
`timescale 1ns/100ps
// dout = din * MUL / DIV, truncated
module ratio_scale #(
    parameter int unsigned IN_W  = 8,
    parameter int unsigned OUT_W = 8,
    parameter int unsigned MUL   = 1,
    parameter int unsigned DIV   = 1
) (
    // operand
    input  wire logic [IN_W-1:0]  din,
    // result
    output logic      [OUT_W-1:0] dout
);
    logic [31:0] prod;

    always_comb
    begin
        prod = 32'(din) * 32'(MUL);
        dout = OUT_W'(prod / 32'(DIV));
    end

endmodule: ratio_scale

// ### foc_gain_config_regs.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module foc_gain_config_regs #(
    parameter int unsigned AW = 12
) (
    // clock, reset, enable
    input  wire logic                                core_clk,
    input  wire logic                                rst_n,
    input  wire logic                                ce,
    // axi4-lite write address
    input  wire logic [AW-1:0]                       s_axi_awaddr,
    input  wire logic [2:0]                          s_axi_awprot,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0]                       s_axi_araddr,
    input  wire logic [2:0]                          s_axi_arprot,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    // decoded configuration
    output logic [foc_gain_pkg::EMF_W-1:0]           motor_back_emf_code,
    output logic                                     cur_gain_auto,
    output logic [foc_gain_pkg::NUMER_W-1:0]         current_loop_prop_gain,
    output logic [foc_gain_pkg::EXP_W-1:0]           current_loop_prop_exp,
    output logic [foc_gain_pkg::NUMER_W-1:0]         current_loop_integ_gain,
    output logic [foc_gain_pkg::EXP_W-1:0]           current_loop_integ_exp,
    output logic [foc_gain_pkg::NUMER_W-1:0]         speed_loop_prop_gain,
    output logic [foc_gain_pkg::EXP_W-1:0]           speed_loop_prop_exp,
    output logic [foc_gain_pkg::NUMER_W-1:0]         speed_loop_integ_gain,
    output logic [foc_gain_pkg::EXP_W-1:0]           speed_loop_integ_exp,
    output logic [foc_gain_pkg::HZ_W-1:0]            max_speed_hz,
    output foc_gain_pkg::shape_t                     ref_shape,
    output logic [foc_gain_pkg::PCT_W-1:0]           turn_on_duty_level
);
    import foc_gain_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // one-hot select {ref, speed, gain_a}, zero when unmapped
    function automatic logic [2:0] reg_select(input logic [AW-1:0] addr);
        logic [2:0] sel;
        sel = 3'b000;
        if (addr == AW'(ADDR_GAIN_A))
            sel = 3'b001;
        else if (addr == AW'(ADDR_SPEED))
            sel = 3'b010;
        else if (addr == AW'(ADDR_REF_A))
            sel = 3'b100;
        return sel;
    endfunction: reg_select

    // byte-lane merge, reserved top bit forced low
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        end
        return res & REG_MASK;
    endfunction: merge

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    logic              awready_q;
    logic              wready_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic [AW-1:0]     awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              aw_take;
    logic              w_take;
    logic              wr_fire;
    logic              aw_held_d;
    logic              w_held_d;
    logic [2:0]        wr_sel;

    assign aw_take   = s_axi_awvalid & awready_q;
    assign w_take    = s_axi_wvalid & wready_q;
    assign wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
    assign aw_held_d = wr_fire ? 1'b0 : (aw_held_q | aw_take);
    assign w_held_d  = wr_fire ? 1'b0 : (w_held_q | w_take);
    assign wr_sel    = reg_select(awaddr_q);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
        end
        else if (ce)
        begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awready_q <= ~aw_held_d;
            wready_q  <= ~w_held_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awaddr_q <= '0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end
        else if (ce)
        begin
            if (aw_take)
                awaddr_q <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_sel == 3'b000) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [31:0] gain_a_q;
    logic [31:0] speed_q;
    logic [31:0] ref_a_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_a_q <= RST_GAIN_A;
            speed_q  <= RST_SPEED;
            ref_a_q  <= RST_REF_A;
        end
        else if (ce && wr_fire)
        begin
            if (wr_sel[0])
                gain_a_q <= merge(gain_a_q, wdata_q, wstrb_q);
            if (wr_sel[1])
                speed_q  <= merge(speed_q, wdata_q, wstrb_q);
            if (wr_sel[2])
                ref_a_q  <= merge(ref_a_q, wdata_q, wstrb_q);
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        ar_take;
    logic        rvalid_d;
    logic [2:0]  rd_sel;
    logic [31:0] rd_word;

    assign ar_take  = s_axi_arvalid & arready_q;
    assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
    assign rd_sel   = reg_select(s_axi_araddr);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            3'b001:  rd_word = gain_a_q;
            3'b010:  rd_word = speed_q;
            3'b100:  rd_word = ref_a_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end
        else if (ce)
        begin
            rvalid_q  <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (ar_take)
            begin
                rdata_q <= rd_word & REG_MASK;
                rresp_q <= (rd_sel == 3'b000) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ------------------------------------------------------------------
    // gain decoders
    // ------------------------------------------------------------------
    gain_if ckp_if ();
    gain_if cki_if ();
    gain_if skp_if ();
    gain_if ski_if ();

    assign ckp_if.code = gain_a_q[CKP_LSB +: GAIN_W];
    assign cki_if.code = gain_a_q[CKI_LSB +: GAIN_W];
    assign skp_if.code = {gain_a_q[SKP_HI_W-1:0], speed_q[SKP_LO_LSB +: SKP_LO_W]};
    assign ski_if.code = speed_q[SKI_LSB +: GAIN_W];

    gain_decode #(.MULT(CKP_MULT), .EXTRA_EXP(0)) u_ckp_dec (.g(ckp_if.dec));
    gain_decode #(.MULT(CKI_MULT), .EXTRA_EXP(0)) u_cki_dec (.g(cki_if.dec));
    gain_decode #(.MULT(1), .EXTRA_EXP(SKP_EXTRA_EXP)) u_skp_dec (.g(skp_if.dec));
    gain_decode #(.MULT(1), .EXTRA_EXP(SKI_EXTRA_EXP)) u_ski_dec (.g(ski_if.dec));

    // ------------------------------------------------------------------
    // speed limit and duty scaling
    // ------------------------------------------------------------------
    logic [HZ_W-1:0]  hz_calc;
    logic [PCT_W-1:0] pct_calc;

    ratio_scale #(.IN_W(SPD_W), .OUT_W(HZ_W), .MUL(1), .DIV(SPD_DIV)) u_hz (
        .din  (speed_q[SPD_LSB +: SPD_W]),
        .dout (hz_calc)
    );

    ratio_scale #(.IN_W(DUTY_W), .OUT_W(PCT_W), .MUL(PCT_FULL), .DIV(DUTY_FULL)) u_pct (
        .din  (ref_a_q[DUTY_LSB +: DUTY_W]),
        .dout (pct_calc)
    );

    shape_t shape_calc;

    always_comb
    begin
        case (ref_a_q[SHAPE_LSB +: 2])
            2'h0:    shape_calc = SHAPE_EQUATION;
            2'h1:    shape_calc = SHAPE_LINEAR;
            2'h2:    shape_calc = SHAPE_STAIRCASE;
            2'h3:    shape_calc = SHAPE_FWD_REV;
            default: shape_calc = SHAPE_EQUATION;
        endcase
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            motor_back_emf_code     <= '0;
            cur_gain_auto           <= 1'b1;
            current_loop_prop_gain  <= '0;
            current_loop_prop_exp   <= '0;
            current_loop_integ_gain <= '0;
            current_loop_integ_exp  <= '0;
            speed_loop_prop_gain    <= '0;
            speed_loop_prop_exp     <= EXP_W'(SKP_EXTRA_EXP);
            speed_loop_integ_gain   <= '0;
            speed_loop_integ_exp    <= EXP_W'(SKI_EXTRA_EXP);
            max_speed_hz            <= '0;
            ref_shape               <= SHAPE_EQUATION;
            turn_on_duty_level      <= '0;
        end
        else if (ce)
        begin
            motor_back_emf_code     <= gain_a_q[EMF_LSB +: EMF_W];
            cur_gain_auto           <= (ckp_if.code == '0) && (cki_if.code == '0);
            current_loop_prop_gain  <= ckp_if.numer;
            current_loop_prop_exp   <= ckp_if.expo;
            current_loop_integ_gain <= cki_if.numer;
            current_loop_integ_exp  <= cki_if.expo;
            speed_loop_prop_gain    <= skp_if.numer;
            speed_loop_prop_exp     <= skp_if.expo;
            speed_loop_integ_gain   <= ski_if.numer;
            speed_loop_integ_exp    <= ski_if.expo;
            max_speed_hz            <= hz_calc;
            ref_shape               <= shape_calc;
            turn_on_duty_level      <= pct_calc;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_write_gain_a;
        ce && wr_fire && wr_sel[0] && (wstrb_q == 4'hF);
    endsequence

    a_gain_a_write: assert property (s_write_gain_a |=> gain_a_q == ($past(wdata_q) & REG_MASK))
        else $error("first gain register did not take a full write");

    a_reserved_read: assert property (s_axi_rvalid |-> !s_axi_rdata[31])
        else $error("reserved bit read back as one");

    a_back_emf_code: assert property (ce |=> motor_back_emf_code == $past(gain_a_q[30:23]))
        else $error("back-emf code output does not follow bits 30-23");

    a_current_auto: assert property (ce && gain_a_q[22:3] == 20'h00000 |=> cur_gain_auto)
        else $error("auto current gain not flagged for zero codes");

    a_current_kp: assert property (ce |=> current_loop_prop_gain == 18'($past(gain_a_q[20:13]))
                                   && current_loop_prop_exp == 3'($past(gain_a_q[22:21])))
        else $error("current proportional gain decode wrong");

    a_current_ki: assert property (ce |=> current_loop_integ_gain ==
                                   18'($past(gain_a_q[10:3])) * 18'd1000)
        else $error("current integral numerator wrong");

    a_speed_kp_join: assert property (ce |=> speed_loop_prop_gain ==
                                      18'({$past(gain_a_q[0]), $past(speed_q[30:24])})
                                      && speed_loop_prop_exp == 3'($past(gain_a_q[2:1])) + 3'd2)
        else $error("speed proportional code not joined correctly");

    a_speed_ki_exp: assert property (ce |=> speed_loop_integ_exp == 3'($past(speed_q[23:22])) + 3'd1
                                     && speed_loop_integ_gain == 18'($past(speed_q[21:14])))
        else $error("speed integral decode wrong");

    a_speed_limit: assert property (ce |=> 32'(max_speed_hz) * 32'd6 <= 32'($past(speed_q[13:0]))
                                    && 32'($past(speed_q[13:0])) < (32'(max_speed_hz) + 32'd1) * 32'd6)
        else $error("maximum speed is not the field over six");

    a_duty_percent: assert property (ce |=> 32'(turn_on_duty_level) * 32'd255 <=
                                     32'($past(ref_a_q[28:21])) * 32'd100
                                     && 32'($past(ref_a_q[28:21])) * 32'd100 <
                                     (32'(turn_on_duty_level) + 32'd1) * 32'd255)
        else $error("turn-on duty percent is not the truncated ratio");

    a_shape_select: assert property (ce && ref_a_q[30:29] == 2'h2 |=> ref_shape == SHAPE_STAIRCASE)
        else $error("staircase shape not selected");

    a_write_resp: assert property (ce && wr_fire |=> s_axi_bvalid)
        else $error("write response missing after write");

    // answer one cycle after the take, data held on the next cycle if it still stands
    sequence s_read_answer;
        s_axi_rvalid ##1 (!s_axi_rvalid || $stable(s_axi_rdata));
    endsequence

    a_read_resp: assert property (ce && ar_take |=> s_read_answer)
        else $error("read response missing or not held after address");

endmodule: foc_gain_config_regs

// ### host_model.sv
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic        core_clk,
    // write channels
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // read channels
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    initial {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask: wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask: rd
endmodule: host_model

// ### foc_gain_config_regs_bench.sv
`timescale 1ns/100ps
`define chk(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, a); end end
module foc_gain_config_regs_bench;
    import foc_gain_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, ref_shape;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cur_gain_auto;
    logic [EMF_W-1:0] motor_back_emf_code;
    logic [NUMER_W-1:0] current_loop_prop_gain, current_loop_integ_gain;
    logic [NUMER_W-1:0] speed_loop_prop_gain, speed_loop_integ_gain;
    logic [EXP_W-1:0] current_loop_prop_exp, current_loop_integ_exp;
    logic [EXP_W-1:0] speed_loop_prop_exp, speed_loop_integ_exp;
    logic [HZ_W-1:0] max_speed_hz;
    logic [PCT_W-1:0] turn_on_duty_level;
    int err_count = 0, total_checks = 0, cyc = 0;
    foc_gain_config_regs dut_u (.*);
    host_model host_u (.*);
    initial forever #5 core_clk = ~core_clk;
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        host_u.wr({2'h0, a}, d, 4'hF, rsp);
        `chk("bresp", RESP_OKAY, rsp)
    endtask: wr
    task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
        host_u.rd({2'h0, a}, rdv, rsp);
        `chk("rdata", e, rdv)
        `chk("rresp", RESP_OKAY, rsp)
    endtask: rdchk
    task automatic t_reset;
        rdchk(ADDR_GAIN_A, 32'h0);
        rdchk(ADDR_SPEED, 32'h0);
        rdchk(ADDR_REF_A, 32'h0);
        `chk("auto", 1'b1, cur_gain_auto)
    endtask: t_reset
    task automatic t_gains;
        wr(ADDR_GAIN_A, 32'hFFFF_FFFF);
        rdchk(ADDR_GAIN_A, 32'h7FFF_FFFF);
        wr(ADDR_GAIN_A, {1'b0, 8'hA5, 10'h237, 10'h14B, 3'h5});
        wr(ADDR_SPEED, {1'b0, 7'h2C, 10'h312, 14'h2710});
        repeat (3) @(posedge core_clk);
        `chk("emf", 8'hA5, motor_back_emf_code)
        `chk("ckp", {18'h37, 3'h2}, {current_loop_prop_gain, current_loop_prop_exp})
        `chk("cki", {18'd75000, 3'h1}, {current_loop_integ_gain, current_loop_integ_exp})
        `chk("skp", {18'hAC, 3'h4}, {speed_loop_prop_gain, speed_loop_prop_exp})
        `chk("ski", {18'h12, 3'h4}, {speed_loop_integ_gain, speed_loop_integ_exp})
        `chk("hz", 12'd1666, max_speed_hz)
        `chk("auto", 1'b0, cur_gain_auto)
        wr(ADDR_GAIN_A, {1'b0, 8'h01, 23'h0});
        repeat (3) @(posedge core_clk);
        `chk("auto", 1'b1, cur_gain_auto)
    endtask: t_gains
    task automatic t_ref;
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_REF_A, {1'b0, 2'(k), 8'(k * 85), 21'h0});
            repeat (3) @(posedge core_clk);
            `chk("shape", 4'(1 << k), ref_shape)
            `chk("duty", 7'(k * 100 / 3), turn_on_duty_level)
        end
    endtask: t_ref
    task automatic t_other;
        host_u.wr(12'h004, 32'h1234_5678, 4'hF, rsp);
        `chk("bresp", RESP_SLVERR, rsp)
        host_u.rd(12'h004, rdv, rsp);
        `chk("rresp", {RESP_SLVERR, 32'h0}, {rsp, rdv})
        host_u.wr({2'h0, ADDR_SPEED}, 32'h0, 4'h1, rsp);
        rdchk(ADDR_SPEED, {1'b0, 7'h2C, 10'h312, 14'h2700});
    endtask: t_other
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask: stop_test
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test;
        end
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_gains;
        t_ref;
        t_other;
        stop_test;
    end
endmodule: foc_gain_config_regs_bench
